// ---- tws_pkg.sv ----
package tws_pkg;

    // ----------------------------------------------------------------
    // clock and times
    // ----------------------------------------------------------------
    localparam real CLK_PERIOD_NS = 5.0;
    localparam real POWER_UP_WAIT_TIME_MS = 10.0;
    localparam int unsigned POWER_UP_WAIT_CYC =
        int'($ceil(POWER_UP_WAIT_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam real CLOCK_LOW_STALL_LIMIT_US = 100.0;
    localparam int unsigned STALL_LIMIT_CYC =
        int'($ceil(CLOCK_LOW_STALL_LIMIT_US * 1.0e3 / CLK_PERIOD_NS));
    localparam int unsigned FILT_LEN_CYC = 3;
    localparam int unsigned SCL_QTR_CYC = 8;

    // ----------------------------------------------------------------
    // byte framing and address byte
    // ----------------------------------------------------------------
    localparam logic [3:0] TYPE_MEM = 4'ha;
    localparam logic [3:0] TYPE_AUX = 4'h6;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam logic [3:0] FRAME_LAST_BIT = 4'h8;
    localparam logic [8:0] FRAME_RELEASED = 9'h1ff;
    localparam logic LINE_IDLE = 1'b1;

    // ----------------------------------------------------------------
    // host command codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_START = 3'h0,
        OP_WRITE = 3'h1,
        OP_READ = 3'h2,
        OP_STOP = 3'h3,
        OP_RECOVER = 3'h4
    } tws_op_t;

endpackage

// ---- tws_if.sv ----
interface tws_if;

    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and of open-drain drivers, pull-up gives the high level
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

    modport host (
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe,
        input scl,
        input sda
    );

    modport dev (
        output dev_sda_o,
        output dev_sda_oe,
        input scl,
        input sda
    );

endinterface

// ---- tws_in_filter.sv ----
module tws_in_filter #(
    parameter int unsigned LEN = tws_pkg::FILT_LEN_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);

    logic meta_ff;
    logic sync_ff;
    logic out_ff;
    logic [7:0] run_ff;

    // two-flop synchroniser, first stage read only by the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= tws_pkg::LINE_IDLE;
            sync_ff <= tws_pkg::LINE_IDLE;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    // a new level must hold LEN samples, so spikes never pass
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_ff <= tws_pkg::LINE_IDLE;
            run_ff <= '0;
        end else if (sync_ff == out_ff) begin
            run_ff <= '0;
        end else if (run_ff == 8'(LEN - 1)) begin
            out_ff <= sync_ff;
            run_ff <= '0;
        end else begin
            run_ff <= run_ff + 8'h01;
        end
    end

    assign dout = out_ff;

endmodule

// ---- tws_dev.sv ----
// Function
// - sample on scl rise, drive after fall
// - msb first, ninth clock acknowledges
// - no gaps inside byte or acknowledge
// - host moves sda only while scl low
// - sda fall with scl high starts
// - sda rise with scl high stops, idle
// - repeated start begins new operation
// - host leaves both lines high idle
// - no limit on bytes per transfer
// - pull sda low whole ninth clock
// - host nack ends reading, sda released
// - nack invalid operations
// - standby at power-up and after stop
// - host waits power-up time first
// - scl stuck low resets, releases sda
// - host keeps scl at least 10kHz
// - recovery: start, nine clocks, start, stop
// - filter glitches on scl and sda
// - address byte matches type and pins
// - address lsb one reads, zero writes
module tws_dev #(
    parameter int unsigned STALL_CYC = tws_pkg::STALL_LIMIT_CYC,
    parameter int unsigned FILT_LEN = tws_pkg::FILT_LEN_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    tws_if.dev bus,
    input wire logic [2:0] addr_pins,
    input wire logic op_busy,
    input wire logic rx_refuse,
    input wire logic [7:0] tx_data,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic tx_take,
    output logic sel_hit,
    output logic sel_aux,
    output logic sel_read,
    output logic xfer_end,
    output logic stall_seen,
    output logic standby
);

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ADDR = 6'h02,
        S_RX = 6'h04,
        S_ACK = 6'h08,
        S_TX = 6'h10,
        S_MACK = 6'h20
    } tws_dst_t;

    localparam logic [31:0] STALL_LAST = 32'(STALL_CYC - 1);
    localparam logic [31:0] STALL_HOLD = 32'(STALL_CYC);

    tws_dst_t state_ff;
    logic scl_f;
    logic sda_f;
    logic scl_d_ff;
    logic sda_d_ff;
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_ff;
    logic [31:0] low_cnt_ff;
    logic [2:0] cnt_ff;
    logic [7:0] sh_ff;
    logic [7:0] tx_sh_ff;
    logic byte_done_ff;
    logic ack_ok_ff;
    logic rd_ff;
    logic mnack_ff;
    logic sda_oe_ff;
    logic [7:0] rx_data_ff;
    logic rx_valid_ff;
    logic tx_take_ff;
    logic sel_hit_ff;
    logic sel_aux_ff;
    logic sel_read_ff;
    logic xfer_end_ff;
    logic stall_seen_ff;
    logic standby_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic stall_ev;
    logic eng_go;
    logic byte_end;
    logic addr_hit;
    logic nxt_ack;
    logic ld_tx;

    // ----------------------------------------------------------------
    // input conditioning
    // ----------------------------------------------------------------
    // spike filters also hold the two synchroniser stages
    tws_in_filter #(.LEN(FILT_LEN)) u_scl_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(bus.scl),
        .dout(scl_f)
    );

    tws_in_filter #(.LEN(FILT_LEN)) u_sda_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(bus.sda),
        .dout(sda_f)
    );

    // strap pins are static but still cross into clk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_meta_ff <= '0;
            pin_ff <= '0;
        end else begin
            pin_meta_ff <= addr_pins;
            pin_ff <= pin_meta_ff;
        end
    end

    // previous filtered levels for edge finding
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d_ff <= tws_pkg::LINE_IDLE;
            sda_d_ff <= tws_pkg::LINE_IDLE;
        end else begin
            scl_d_ff <= scl_f;
            sda_d_ff <= sda_f;
        end
    end

    // both lines share the same filter delay, so conditions stay aligned
    assign scl_rise = scl_f & ~scl_d_ff;
    assign scl_fall = ~scl_f & scl_d_ff;
    assign start_ev = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
    assign stop_ev = scl_f & scl_d_ff & ~sda_d_ff & sda_f;

    // ----------------------------------------------------------------
    // scl low watchdog
    // ----------------------------------------------------------------
    // saturates past the limit so the event fires once per stall
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cnt_ff <= '0;
        end else if (scl_f) begin
            low_cnt_ff <= '0;
        end else if (low_cnt_ff != STALL_HOLD) begin
            low_cnt_ff <= low_cnt_ff + 32'h1;
        end
    end

    assign stall_ev = ~scl_f & (low_cnt_ff == STALL_LAST);

    // ----------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------
    assign eng_go = ~stall_ev & ~start_ev & ~stop_ev;
    assign byte_end = ((state_ff == S_ADDR) | (state_ff == S_RX))
        & scl_fall & byte_done_ff & eng_go;
    assign addr_hit = ((sh_ff[7:4] == tws_pkg::TYPE_MEM)
        | (sh_ff[7:4] == tws_pkg::TYPE_AUX))
        & (sh_ff[3:1] == pin_ff);
    assign nxt_ack = (state_ff == S_ADDR) ? addr_hit : ~rx_refuse;
    assign ld_tx = eng_go & scl_fall
        & (((state_ff == S_ACK) & ack_ok_ff & rd_ff)
        | ((state_ff == S_MACK) & ~mnack_ff));

    // stall beats start beats stop; every abort frees sda at once
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= S_IDLE;
            cnt_ff <= '0;
            sh_ff <= '0;
            tx_sh_ff <= '0;
            byte_done_ff <= 1'b0;
            ack_ok_ff <= 1'b0;
            rd_ff <= 1'b0;
            mnack_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (stall_ev) begin
            state_ff <= S_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (start_ev) begin
            state_ff <= S_ADDR;
            cnt_ff <= '0;
            byte_done_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (stop_ev) begin
            state_ff <= S_IDLE;
            sda_oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    sda_oe_ff <= 1'b0;
                end
                S_ADDR, S_RX: begin
                    if (scl_rise && !byte_done_ff) begin
                        sh_ff <= {sh_ff[6:0], sda_f};
                        cnt_ff <= cnt_ff + 3'h1;
                        if (cnt_ff == tws_pkg::BYTE_LAST_BIT) begin
                            byte_done_ff <= 1'b1;
                        end
                    end else if (byte_end) begin
                        byte_done_ff <= 1'b0;
                        ack_ok_ff <= nxt_ack;
                        sda_oe_ff <= nxt_ack;
                        state_ff <= S_ACK;
                        if (state_ff == S_ADDR) begin
                            rd_ff <= sh_ff[0];
                        end
                    end
                end
                S_ACK: begin
                    // low stays through the whole high phase
                    if (ld_tx) begin
                        tx_sh_ff <= tx_data;
                        sda_oe_ff <= ~tx_data[7];
                        cnt_ff <= '0;
                        state_ff <= S_TX;
                    end else if (scl_fall) begin
                        sda_oe_ff <= 1'b0;
                        state_ff <= ack_ok_ff ? S_RX : S_IDLE;
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (cnt_ff == tws_pkg::BYTE_LAST_BIT) begin
                            sda_oe_ff <= 1'b0;
                            cnt_ff <= '0;
                            state_ff <= S_MACK;
                        end else begin
                            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                            sda_oe_ff <= ~tx_sh_ff[6];
                            cnt_ff <= cnt_ff + 3'h1;
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        mnack_ff <= sda_f;
                    end else if (ld_tx) begin
                        tx_sh_ff <= tx_data;
                        sda_oe_ff <= ~tx_data[7];
                        state_ff <= S_TX;
                    end else if (scl_fall) begin
                        sda_oe_ff <= 1'b0;
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // user side
    // ----------------------------------------------------------------
    // received bytes and selection, one-cycle strobes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_data_ff <= '0;
            rx_valid_ff <= 1'b0;
            sel_hit_ff <= 1'b0;
            sel_aux_ff <= 1'b0;
            sel_read_ff <= 1'b0;
        end else begin
            rx_valid_ff <= byte_end & (state_ff == S_RX) & nxt_ack;
            sel_hit_ff <= byte_end & (state_ff == S_ADDR) & addr_hit;
            if (byte_end && state_ff == S_RX && nxt_ack) begin
                rx_data_ff <= sh_ff;
            end
            if (byte_end && state_ff == S_ADDR && addr_hit) begin
                sel_aux_ff <= (sh_ff[7:4] == tws_pkg::TYPE_AUX);
                sel_read_ff <= sh_ff[0];
            end
        end
    end

    // bus events and power state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_take_ff <= 1'b0;
            xfer_end_ff <= 1'b0;
            stall_seen_ff <= 1'b0;
            standby_ff <= 1'b1;
        end else begin
            tx_take_ff <= ld_tx;
            xfer_end_ff <= stop_ev & ~stall_ev;
            stall_seen_ff <= stall_ev;
            // a pending write cycle keeps the device awake after stop
            standby_ff <= (state_ff == S_IDLE) & ~op_busy;
        end
    end

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = sda_oe_ff;
    assign rx_data = rx_data_ff;
    assign rx_valid = rx_valid_ff;
    assign tx_take = tx_take_ff;
    assign sel_hit = sel_hit_ff;
    assign sel_aux = sel_aux_ff;
    assign sel_read = sel_read_ff;
    assign xfer_end = xfer_end_ff;
    assign stall_seen = stall_seen_ff;
    assign standby = standby_ff;

endmodule

// ---- tws_host.sv ----
module tws_host #(
    parameter int unsigned QTR = tws_pkg::SCL_QTR_CYC,
    parameter int unsigned PWRUP_CYC = tws_pkg::POWER_UP_WAIT_CYC,
    parameter int unsigned FILT_LEN = tws_pkg::FILT_LEN_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    tws_if.host bus,
    input wire logic cmd_valid,
    input wire tws_pkg::tws_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    output logic cmd_ready,
    output logic cmd_done,
    output logic [7:0] rd_data,
    output logic dev_ack
);

    typedef enum logic [4:0] {
        H_WAIT = 5'h01,
        H_IDLE = 5'h02,
        H_START = 5'h04,
        H_BITS = 5'h08,
        H_STOP = 5'h10
    } tws_hst_t;

    tws_hst_t state_ff;
    logic sda_f;
    logic [31:0] pw_cnt_ff;
    logic [15:0] q_cnt_ff;
    logic [1:0] step_ff;
    logic [3:0] bit_ff;
    logic [1:0] rec_ff;
    logic [8:0] sh_ff;
    logic [8:0] smp_ff;
    logic scl_oe_ff;
    logic sda_oe_ff;
    logic ready_ff;
    logic done_ff;
    logic [7:0] rd_data_ff;
    logic ack_ff;
    logic tick;
    logic busy;

    tws_in_filter #(.LEN(FILT_LEN)) u_sda_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(bus.sda),
        .dout(sda_f)
    );

    // ----------------------------------------------------------------
    // scl divider: four quarter ticks per bit
    // ----------------------------------------------------------------
    // keep 4*QTR below the low-speed limit or the device times out
    assign busy = (state_ff != H_WAIT) & (state_ff != H_IDLE);
    assign tick = q_cnt_ff == 16'(QTR - 1);

    always_ff @(posedge clk) begin
        if (sys_rst || !busy || tick) begin
            q_cnt_ff <= '0;
        end else begin
            q_cnt_ff <= q_cnt_ff + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= H_WAIT;
            pw_cnt_ff <= '0;
            step_ff <= '0;
            bit_ff <= '0;
            rec_ff <= '0;
            sh_ff <= tws_pkg::FRAME_RELEASED;
            smp_ff <= '0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
            rd_data_ff <= '0;
            ack_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                H_WAIT: begin
                    // nothing on the bus until the device has settled
                    if (pw_cnt_ff == 32'(PWRUP_CYC - 1)) begin
                        state_ff <= H_IDLE;
                        ready_ff <= 1'b1;
                    end else begin
                        pw_cnt_ff <= pw_cnt_ff + 32'h1;
                    end
                end
                H_IDLE: begin
                    step_ff <= '0;
                    bit_ff <= '0;
                    if (cmd_valid) begin
                        ready_ff <= 1'b0;
                        case (cmd_op)
                            tws_pkg::OP_START: state_ff <= H_START;
                            tws_pkg::OP_WRITE: begin
                                sh_ff <= {cmd_data, 1'b1};
                                state_ff <= H_BITS;
                            end
                            tws_pkg::OP_READ: begin
                                sh_ff <= {8'hff, cmd_nack};
                                state_ff <= H_BITS;
                            end
                            tws_pkg::OP_STOP: state_ff <= H_STOP;
                            tws_pkg::OP_RECOVER: begin
                                rec_ff <= 2'h1;
                                state_ff <= H_START;
                            end
                            default: ready_ff <= 1'b1;
                        endcase
                    end
                end
                H_START: begin
                    // also a repeated start when entered with scl low
                    if (tick) begin
                        step_ff <= step_ff + 2'h1;
                        case (step_ff)
                            2'h0: sda_oe_ff <= 1'b0;
                            2'h1: scl_oe_ff <= 1'b0;
                            2'h2: sda_oe_ff <= 1'b1;
                            default: begin
                                scl_oe_ff <= 1'b1;
                                if (rec_ff == 2'h1) begin
                                    sh_ff <= tws_pkg::FRAME_RELEASED;
                                    rec_ff <= 2'h2;
                                    state_ff <= H_BITS;
                                end else if (rec_ff == 2'h3) begin
                                    rec_ff <= 2'h0;
                                    state_ff <= H_STOP;
                                end else begin
                                    state_ff <= H_IDLE;
                                    ready_ff <= 1'b1;
                                    done_ff <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
                H_BITS: begin
                    // nine back-to-back clocks, sda moves only with scl low
                    if (tick) begin
                        step_ff <= step_ff + 2'h1;
                        case (step_ff)
                            2'h0: sda_oe_ff <= ~sh_ff[8];
                            2'h1: scl_oe_ff <= 1'b0;
                            2'h2: smp_ff <= {smp_ff[7:0], sda_f};
                            default: begin
                                scl_oe_ff <= 1'b1;
                                sh_ff <= {sh_ff[7:0], 1'b1};
                                bit_ff <= bit_ff + 4'h1;
                                if (bit_ff == tws_pkg::FRAME_LAST_BIT) begin
                                    bit_ff <= '0;
                                    if (rec_ff == 2'h2) begin
                                        rec_ff <= 2'h3;
                                        state_ff <= H_START;
                                    end else begin
                                        rd_data_ff <= smp_ff[8:1];
                                        ack_ff <= ~smp_ff[0];
                                        state_ff <= H_IDLE;
                                        ready_ff <= 1'b1;
                                        done_ff <= 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                end
                H_STOP: begin
                    if (tick) begin
                        step_ff <= step_ff + 2'h1;
                        case (step_ff)
                            2'h0: sda_oe_ff <= 1'b1;
                            2'h1: scl_oe_ff <= 1'b0;
                            default: begin
                                sda_oe_ff <= 1'b0;
                                state_ff <= H_IDLE;
                                ready_ff <= 1'b1;
                                done_ff <= 1'b1;
                            end
                        endcase
                    end
                end
                default: state_ff <= H_IDLE;
            endcase
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe = scl_oe_ff;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = sda_oe_ff;
    assign cmd_ready = ready_ff;
    assign cmd_done = done_ff;
    assign rd_data = rd_data_ff;
    assign dev_ack = ack_ff;

endmodule

// ---- tws_checker.sv ----
module tws_checker #(
    parameter int unsigned STALL_CYC = 200
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    int unsigned low_ff;
    // --------------------------------------------------------------
    // wire checks
    // --------------------------------------------------------------
    // scl low time, saturates so a hung bus cannot wrap it
    always_ff @(posedge clk) begin
        if (sys_rst || scl)
            low_ff <= 0;
        else if (low_ff < 1000)
            low_ff <= low_ff + 1;
    end
    a_dev_moves_low:
        assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device moved sda while scl high");
    a_ack_whole_high:
        assert property (dev_sda_oe && $rose(scl) |-> dev_sda_oe [*8])
        else $error("device let go of sda in a high phase");
    a_host_let_go:
        assert property (dev_sda_oe && scl |-> !host_sda_oe)
        else $error("host drives sda beside the device");
    a_scl_high_len:
        assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase cut short");
    a_scl_low_len:
        assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase cut short");
    a_stop_idle:
        assert property ($fell(host_sda_oe) && scl |-> (scl && sda) [*8])
        else $error("bus not idle after stop");
    a_start_clocks:
        assert property ($rose(host_sda_oe) && scl |-> ##[1:24] !scl)
        else $error("no clock after start");
    a_stall_frees:
        assert property (low_ff > STALL_CYC + 32 |-> !dev_sda_oe)
        else $error("sda held through scl stall");
    c_dev_pulls: cover property ($rose(dev_sda_oe));
    c_stall: cover property (low_ff == STALL_CYC);
    c_stop: cover property ($fell(host_sda_oe) && scl);
endmodule

// ---- test_two_wire_slave_bus_interface.sv ----
module test_two_wire_slave_bus_interface;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned STALL = 200;
    logic clk = 0, sys_rst = 1, cmd_valid = 0, cmd_nack = 0, xfer_end;
    logic op_busy = 0, rx_refuse = 0, dev_ack, cmd_ready, cmd_done, rx_valid;
    logic tx_take, sel_aux, sel_read, stall_seen, standby, sel_hit, hung = 0;
    logic [2:0] pins = 0;
    logic [7:0] tx_data = 0, cmd_data = 0, rx_data, rd_data;
    tws_pkg::tws_op_t cmd_op = tws_pkg::OP_START;
    logic [31:0] rnd = 32'hae0e4262;
    logic [11:0] evs = 12'h000;
    logic [7:0] txq[$];
    int n_fail = 0, compares = 0, cyc = 0;
    tws_if bus();
    tws_host #(.PWRUP_CYC(50)) u_tws_host (.clk(clk), .sys_rst(sys_rst),
        .bus(bus.host), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready),
        .cmd_done(cmd_done), .rd_data(rd_data), .dev_ack(dev_ack));
    tws_dev #(.STALL_CYC(STALL)) u_tws_dev (.clk(clk), .sys_rst(sys_rst),
        .bus(bus.dev), .addr_pins(pins), .op_busy(op_busy),
        .rx_refuse(rx_refuse), .tx_data(tx_data), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_take(tx_take), .sel_hit(sel_hit),
        .sel_aux(sel_aux), .sel_read(sel_read), .xfer_end(xfer_end),
        .stall_seen(stall_seen), .standby(standby));
    tws_checker #(.STALL_CYC(STALL)) u_tws_checker (.clk(clk),
        .sys_rst(sys_rst), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one host command, returns after done
    task automatic cmd(input tws_pkg::tws_op_t op, input logic [7:0] d,
        input logic nk);
        @(posedge clk);
        cmd_valid <= 1;
        cmd_op <= op;
        cmd_data <= d;
        cmd_nack <= nk;
        @(posedge clk);
        while (!cmd_ready) @(posedge clk);
        cmd_valid <= 0;
        @(posedge clk);
        while (!cmd_done) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] d, input logic ack);
        cmd(tws_pkg::OP_WRITE, d, 0);
        chk(8'(dev_ack), 8'(ack));
    endtask
    // sent-byte model and event counts
    always @(posedge clk) begin
        cyc <= cyc + 1;
        evs <= evs + {xfer_end, 3'h0, sel_hit, 3'h0, rx_valid};
        if (stall_seen)
            hung <= 1;
        if (tx_take) begin
            txq.push_back(tx_data);
            tx_data <= rnd[15:8];
        end
        if (cyc == 40000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        pins <= rnd[2:0];
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        cmd(tws_pkg::OP_START, 0, 0);
        wr({4'ha, pins, 1'b0}, 1);
        chk(8'({sel_aux, sel_read}), 8'h0);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            wr(rnd[7:0], 1);
            chk(rx_data, rnd[7:0]);
        end
        op_busy <= 1;
        cmd(tws_pkg::OP_STOP, 0, 0);
        repeat (20) @(posedge clk);
        chk(8'(standby), 8'h0);
        op_busy <= 0;
        repeat (4) @(posedge clk);
        chk(8'(standby), 8'h1);
        $display("write test done");
        cmd(tws_pkg::OP_START, 0, 0);
        wr({4'ha, ~pins, 1'b0}, 0);
        cmd(tws_pkg::OP_START, 0, 0);
        wr({4'h5, pins, 1'b0}, 0);
        cmd(tws_pkg::OP_STOP, 0, 0);
        $display("address test done");
        cmd(tws_pkg::OP_START, 0, 0);
        wr({4'h6, pins, 1'b0}, 1);
        chk(8'(sel_aux), 8'h1);
        wr(rnd[23:16], 1);
        cmd(tws_pkg::OP_START, 0, 0);
        txq.delete();
        wr({4'ha, pins, 1'b1}, 1);
        chk(8'(sel_read), 8'h1);
        for (int k = 0; k < 3; k++) begin
            cmd(tws_pkg::OP_READ, 0, k == 2);
            chk(rd_data, txq.pop_front());
        end
        cmd(tws_pkg::OP_STOP, 0, 0);
        $display("read test done");
        cmd(tws_pkg::OP_START, 0, 0);
        wr({4'ha, pins, 1'b0}, 1);
        rx_refuse <= 1;
        wr(rnd[31:24], 0);
        rx_refuse <= 0;
        cmd(tws_pkg::OP_STOP, 0, 0);
        $display("refuse test done");
        tx_data <= 8'h3c;
        cmd(tws_pkg::OP_START, 0, 0);
        wr({4'ha, pins, 1'b1}, 1);
        repeat (STALL + 100) @(posedge clk);
        chk(8'({hung, bus.sda}), 8'h3);
        cmd(tws_pkg::OP_RECOVER, 0, 0);
        cmd(tws_pkg::OP_START, 0, 0);
        wr({4'ha, pins, 1'b0}, 1);
        chk(evs[7:0], 8'h64);
        chk(8'(evs[11:8]), 8'h05);
        cmd(tws_pkg::OP_STOP, 0, 0);
        $display("stall test done");
        stop_test();
    end
endmodule
